// File: verilog/rsq_pkg.sv
package rsq_pkg;
    // Default oscillation settle exponent: 2**15 peripheral clock cycles
    localparam int RSQ_SETTLE_EXP    = 15;
    localparam int RSQ_SYNC_STAGES   = 2;
    // Peripheral divider chain reaches the 1024 division
    localparam int RSQ_PER_DIV_WIDTH = 10;
    localparam logic RSQ_ASSERTED    = 1'b1;
    localparam logic RSQ_RELEASED    = 1'b0;

    typedef enum logic [1:0] {
        RSQ_CAUSE_NONE,
        RSQ_CAUSE_PIN,
        RSQ_CAUSE_WDOG1,
        RSQ_CAUSE_WDOG2
    } rsq_cause_t;

    typedef enum {
        RSQ_ST_RESET,
        RSQ_ST_SETTLE,
        RSQ_ST_RUN
    } rsq_state_t;
endpackage

// File: verilog/rsq_sync.sv
`timescale 1ns/1ps
// Two-stage level synchroniser for an asynchronous input
module rsq_sync
    import rsq_pkg::*;
#(
    parameter logic RESET_VALUE = 1'b0
) (
    // Clock and reset
    input  wire logic mclk_i,
    input  wire logic rst_b_i,
    input  wire logic ce_i,
    // Level in and out
    input  wire logic async_i,
    output logic      sync_o
);
    logic stage1;
    logic stage2;
    logic next_stage1;
    logic next_stage2;

    // Hold while the clock enable is low
    always_comb begin
        next_stage1 = ce_i ? async_i : stage1;
        next_stage2 = ce_i ? stage1  : stage2;
    end

    // First stage feeds the second stage only
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stage1 <= RESET_VALUE;
            stage2 <= RESET_VALUE;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
        end
    end

    assign sync_o = stage2;
endmodule

// File: verilog/rsq_reset_seq.sv
`timescale 1ns/1ps
module rsq_reset_seq
    import rsq_pkg::*;
#(
    parameter int SETTLE_CYCLES = 2 ** RSQ_SETTLE_EXP
) (
    // Clock, reset and enable
    input  wire logic mclk_i,
    input  wire logic rst_b_i,
    input  wire logic ce_i,
    // Reset sources
    input  wire logic reset_pin_b_i,
    input  wire logic wdog1_overflow_reset_i,
    input  wire logic wdog2_overflow_reset_i,
    // Power mode and strap
    input  wire logic stop_mode_i,
    input  wire logic sub_idle_mode_i,
    input  wire logic regulator_cap_pin_i,
    // Clock gates
    output logic      main_osc_en_o,
    output logic      sub_osc_en_o,
    output logic      periph_clk_en_o,
    output logic      internal_system_clk_en_o,
    output logic      cpu_core_clk_en_o,
    output logic      wdog1_clk_en_o,
    // Resets and status
    output logic      periph_reset_o,
    output logic      cpu_reset_o,
    output logic      ram_write_block_o,
    output logic      regulator_stop_o,
    output logic      settling_o
);
    localparam int CW = $clog2(SETTLE_CYCLES + 1);
    localparam logic [CW-1:0] SETTLE_LAST = CW'(SETTLE_CYCLES - 1);
    localparam logic [CW-1:0] CNT_ZERO    = '0;

    logic       pin_b_s;
    logic       wd1_s;
    logic       wd2_s;
    logic       src_osc;    // pin or second watchdog
    logic       src_any;
    rsq_state_t state;
    rsq_state_t next_state;
    rsq_cause_t cause;
    rsq_cause_t next_cause;
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic       strap;
    logic       next_strap;

    // Every source crosses two flops first
    rsq_sync #(.RESET_VALUE(1'b0)) u_pin_sync (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .ce_i    (ce_i),
        .async_i (reset_pin_b_i),
        .sync_o  (pin_b_s)
    );
    rsq_sync #(.RESET_VALUE(1'b0)) u_wd1_sync (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .ce_i    (ce_i),
        .async_i (wdog1_overflow_reset_i),
        .sync_o  (wd1_s)
    );
    rsq_sync #(.RESET_VALUE(1'b0)) u_wd2_sync (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .ce_i    (ce_i),
        .async_i (wdog2_overflow_reset_i),
        .sync_o  (wd2_s)
    );

    assign src_osc = !pin_b_s || wd2_s;
    assign src_any = src_osc || wd1_s;

    // Sequencer next state; oscillator-stopping causes win over the first watchdog
    always_comb begin
        next_state = state;
        next_cause = cause;
        next_cnt   = cnt;
        if (src_any) begin
            next_state = RSQ_ST_RESET;
            next_cnt   = CNT_ZERO;
            if (!pin_b_s) begin
                next_cause = RSQ_CAUSE_PIN;
            end else if (wd2_s) begin
                next_cause = RSQ_CAUSE_WDOG2;
            end else if (cause != RSQ_CAUSE_PIN && cause != RSQ_CAUSE_WDOG2) begin
                next_cause = RSQ_CAUSE_WDOG1;
            end
        end else begin
            unique case (state)
                RSQ_ST_RESET: begin
                    if (cause == RSQ_CAUSE_WDOG1) begin
                        next_state = RSQ_ST_RUN;
                    end else begin
                        next_state = RSQ_ST_SETTLE;
                    end
                end
                RSQ_ST_SETTLE: begin
                    next_cnt = cnt + 1'b1;
                    if (cnt == SETTLE_LAST) begin
                        next_state = RSQ_ST_RUN;
                    end
                end
                RSQ_ST_RUN: begin
                    next_cause = RSQ_CAUSE_NONE;
                end
            endcase
        end
        if (!ce_i) begin
            next_state = state;
            next_cause = cause;
            next_cnt   = cnt;
        end
    end

    // Power-up enters reset as if from the pin, so the settle count runs
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= RSQ_ST_RESET;
            cause <= RSQ_CAUSE_PIN;
            cnt   <= CNT_ZERO;
        end else begin
            state <= next_state;
            cause <= next_cause;
            cnt   <= next_cnt;
        end
    end

    // Strap caught by a clocked process while reset is held
    always_comb begin
        next_strap = (ce_i && state == RSQ_ST_RESET) ? regulator_cap_pin_i : strap;
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            strap <= 1'b0;
        end else begin
            strap <= next_strap;
        end
    end

    // Clock gates; oscillator runs while the synced pin is high, except in a second-watchdog reset while wd2_s stays high
    assign main_osc_en_o            = pin_b_s &&
                                      !(state == RSQ_ST_RESET && cause == RSQ_CAUSE_WDOG2 && wd2_s);
    assign sub_osc_en_o             = 1'b1;
    assign periph_clk_en_o          = state == RSQ_ST_RUN;
    assign internal_system_clk_en_o = state == RSQ_ST_RUN;
    assign cpu_core_clk_en_o        = state == RSQ_ST_RUN;
    assign wdog1_clk_en_o           = !(state == RSQ_ST_RESET && cause != RSQ_CAUSE_WDOG1);

    // Reset outputs; peripherals start only once running
    assign periph_reset_o    = (state == RSQ_ST_RUN) ? RSQ_RELEASED : RSQ_ASSERTED;
    assign cpu_reset_o       = (state == RSQ_ST_RUN) ? RSQ_RELEASED : RSQ_ASSERTED;
    // Blocks RAM writes in reset so contents survive; a write racing entry is lost
    assign ram_write_block_o = state == RSQ_ST_RESET;
    assign regulator_stop_o  = strap && (state == RSQ_ST_RESET || stop_mode_i || sub_idle_mode_i);
    assign settling_o        = state == RSQ_ST_SETTLE;

    // Assertions
    sequence settle_done_s;
        $past(state) == RSQ_ST_SETTLE && $past(cnt) == SETTLE_LAST && $past(ce_i) && !$past(src_any);
    endsequence

    wd1_fast_start_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (state == RSQ_ST_RESET && cause == RSQ_CAUSE_WDOG1 && !src_any && ce_i) |=> cpu_reset_o == RSQ_RELEASED)
        else $error("first watchdog release did not start cpu at once");
    osc_release_settle_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (state == RSQ_ST_RESET && cause != RSQ_CAUSE_WDOG1 && !src_any && ce_i) |=> settling_o && cnt == CNT_ZERO)
        else $error("pin release did not begin settle from zero");
    settle_clock_off_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        settling_o |-> !cpu_core_clk_en_o && !periph_clk_en_o && !internal_system_clk_en_o)
        else $error("clocks ran during settle");
    any_source_reset_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (src_any && ce_i) |=> periph_reset_o == RSQ_ASSERTED && state == RSQ_ST_RESET)
        else $error("reset source did not assert reset");
    pin_low_osc_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        !pin_b_s |-> !main_osc_en_o)
        else $error("oscillator ran while pin low");
    wd1_clock_runs_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (cause == RSQ_CAUSE_WDOG1 && pin_b_s) |-> wdog1_clk_en_o && main_osc_en_o)
        else $error("watchdog clock stopped in first watchdog reset");
    settle_end_run_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        settle_done_s |-> state == RSQ_ST_RUN && cpu_core_clk_en_o)
        else $error("settle end did not start cpu");
    regulator_stop_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (strap && (stop_mode_i || sub_idle_mode_i)) |-> regulator_stop_o)
        else $error("regulator stop missing in low power mode");
    subclock_on_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        sub_osc_en_o)
        else $error("subclock stopped");

    // One enabled settle cycle with no source present
    sequence settle_step_s;
        state == RSQ_ST_SETTLE && cnt != SETTLE_LAST && ce_i && !src_any;
    endsequence

    // First watchdog arriving behind a pending oscillator-stopping cause
    sequence wd1_behind_osc_s;
        (cause == RSQ_CAUSE_PIN || cause == RSQ_CAUSE_WDOG2) && wd1_s && !src_osc && ce_i;
    endsequence

    settle_count_step_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        settle_step_s |=> state == RSQ_ST_SETTLE && cnt == $past(cnt) + 1'b1)
        else $error("settle count did not advance by one");
    cause_kept_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        wd1_behind_osc_s |=> cause == $past(cause))
        else $error("first watchdog replaced a pending oscillator reset cause");
    enable_freeze_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        !ce_i |=> $stable(state) && $stable(cnt) && $stable(cause) && $stable(strap))
        else $error("state moved while clock enable low");
    wd1_clock_stop_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (state == RSQ_ST_RESET && cause != RSQ_CAUSE_WDOG1) |-> !wdog1_clk_en_o)
        else $error("watchdog clock ran in oscillator reset");
endmodule

// File: sim/rsq_src_model.sv
`timescale 1ns/1ps
// Far side: reset pin driver and both watchdog overflow lines
module rsq_src_model (
    // Clock and command
    input  wire logic       mclk_i,
    input  wire logic       go_i,
    input  wire logic [1:0] kind_i,
    input  wire logic [7:0] len_i,
    // Reset sources
    output logic            reset_pin_b_o,
    output logic            wdog1_o,
    output logic            wdog2_o
);
    logic [7:0] left = 8'h00;
    logic [1:0] kind = 2'h0;

    // Hold the chosen source for len cycles; levels, not pulses
    always @(posedge mclk_i) begin
        if (go_i) begin
            left <= len_i;
            kind <= kind_i;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
    end

    // Release returns each line to its idle level
    assign reset_pin_b_o = !(left != 8'h00 && kind == 2'h1);
    assign wdog1_o       = left != 8'h00 && kind == 2'h2;
    assign wdog2_o       = left != 8'h00 && kind == 2'h3;
endmodule

// File: sim/tb_reset_sequencer_osc_settle.sv
`timescale 1ns/1ps
module tb_reset_sequencer_osc_settle;
    import rsq_pkg::*;
    // Short settle count keeps the run brief
    localparam int SETTLE = 8;
    logic       mclk_i = 0, rst_b_i = 0, ce_i = 1, go = 0;
    logic       stop_mode_i = 0, sub_idle_mode_i = 0, regulator_cap_pin_i = 0;
    logic [1:0] kind = 2'h0;
    logic [7:0] len = 8'h00;
    logic       pin_b, wd1, wd2;
    logic       main_osc_en_o, sub_osc_en_o, periph_clk_en_o, internal_system_clk_en_o;
    logic       cpu_core_clk_en_o, wdog1_clk_en_o, periph_reset_o, cpu_reset_o;
    logic       ram_write_block_o, regulator_stop_o, settling_o;
    int         n_fail = 0, checks_done = 0;

    always #5 mclk_i = ~mclk_i;

    rsq_src_model src (.mclk_i(mclk_i), .go_i(go), .kind_i(kind), .len_i(len),
        .reset_pin_b_o(pin_b), .wdog1_o(wd1), .wdog2_o(wd2));

    rsq_reset_seq #(.SETTLE_CYCLES(SETTLE)) dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
        .reset_pin_b_i(pin_b), .wdog1_overflow_reset_i(wd1), .wdog2_overflow_reset_i(wd2),
        .stop_mode_i(stop_mode_i), .sub_idle_mode_i(sub_idle_mode_i),
        .regulator_cap_pin_i(regulator_cap_pin_i), .main_osc_en_o(main_osc_en_o),
        .sub_osc_en_o(sub_osc_en_o), .periph_clk_en_o(periph_clk_en_o),
        .internal_system_clk_en_o(internal_system_clk_en_o), .cpu_core_clk_en_o(cpu_core_clk_en_o),
        .wdog1_clk_en_o(wdog1_clk_en_o), .periph_reset_o(periph_reset_o), .cpu_reset_o(cpu_reset_o),
        .ram_write_block_o(ram_write_block_o), .regulator_stop_o(regulator_stop_o),
        .settling_o(settling_o));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Inputs move 1 ns after the edge so sampling never races
    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask

    // Source held six cycles; checks land while it is still held
    task automatic fire(input logic [1:0] k);
        kind = k;
        len = 8'h06;
        go = 1;
        step(1);
        go = 0;
        step(5);
    endtask

    // Count settle cycles until the CPU leaves reset, bounded wait
    task automatic settle_len(input logic [15:0] exp);
        int cnt = 0;
        for (int i = 0; i < 60 && cpu_reset_o !== 1'b0; i++) begin
            if (settling_o === 1'b1) cnt++;
            step(1);
        end
        chk("cpu reset", 16'h0000, {15'h0000, cpu_reset_o});
        chk("settle cycles", exp, cnt[15:0]);
        chk("cpu clock", 16'h0001, {15'h0000, cpu_core_clk_en_o});
        chk("periph clock", 16'h0001, {15'h0000, periph_clk_en_o});
    endtask

    task automatic t_pin();
        regulator_cap_pin_i = 1;
        fire(2'h1);
        chk("main osc", 16'h0000, {15'h0000, main_osc_en_o});
        chk("periph reset", 16'h0001, {15'h0000, periph_reset_o});
        chk("wdog1 clock", 16'h0000, {15'h0000, wdog1_clk_en_o});
        chk("periph clock", 16'h0000, {15'h0000, periph_clk_en_o});
        chk("ram block", 16'h0001, {15'h0000, ram_write_block_o});
        chk("sub osc", 16'h0001, {15'h0000, sub_osc_en_o});
        chk("reg stop", 16'h0001, {15'h0000, regulator_stop_o});
        settle_len(16'(SETTLE));
        chk("reg stop run", 16'h0000, {15'h0000, regulator_stop_o});
        stop_mode_i = 1;
        step(1);
        chk("reg stop mode", 16'h0001, {15'h0000, regulator_stop_o});
        stop_mode_i = 0;
        sub_idle_mode_i = 1;
        step(1);
        chk("reg sub idle", 16'h0001, {15'h0000, regulator_stop_o});
        sub_idle_mode_i = 0;
    endtask

    task automatic t_wd1();
        fire(2'h2);
        chk("main osc", 16'h0001, {15'h0000, main_osc_en_o});
        chk("wdog1 clock", 16'h0001, {15'h0000, wdog1_clk_en_o});
        chk("cpu clock", 16'h0000, {15'h0000, cpu_core_clk_en_o});
        chk("cpu reset", 16'h0001, {15'h0000, cpu_reset_o});
        chk("periph reset", 16'h0001, {15'h0000, periph_reset_o});
        settle_len(16'h0000);
    endtask

    task automatic t_wd2();
        fire(2'h3);
        chk("sys clock", 16'h0000, {15'h0000, internal_system_clk_en_o});
        chk("main osc", 16'h0000, {15'h0000, main_osc_en_o});
        chk("wdog1 clock", 16'h0000, {15'h0000, wdog1_clk_en_o});
        chk("periph reset", 16'h0001, {15'h0000, periph_reset_o});
        settle_len(16'(SETTLE));
    endtask

    // Clock enable dropped early in the settle count; the count holds at zero, so a full count remains
    task automatic t_freeze();
        fire(2'h1);
        step(4);
        chk("settling", 16'h0001, {15'h0000, settling_o});
        chk("wdog1 clock settle", 16'h0001, {15'h0000, wdog1_clk_en_o});
        ce_i = 0;
        step(4);
        chk("frozen cpu reset", 16'h0001, {15'h0000, cpu_reset_o});
        ce_i = 1;
        settle_len(16'(SETTLE));
    endtask

    // First watchdog right behind a pin reset must not drop the settle count
    task automatic t_order();
        fire(2'h1);
        fire(2'h2);
        chk("wdog1 clock order", 16'h0000, {15'h0000, wdog1_clk_en_o});
        settle_len(16'(SETTLE));
    endtask

    // Power-on reset in mid-run acts as a pin reset; an open strap keeps the regulator on
    task automatic t_por();
        regulator_cap_pin_i = 0;
        rst_b_i = 0;
        step(2);
        chk("por cpu reset", 16'h0001, {15'h0000, cpu_reset_o});
        chk("por main osc", 16'h0000, {15'h0000, main_osc_en_o});
        chk("por ram block", 16'h0001, {15'h0000, ram_write_block_o});
        rst_b_i = 1;
        settle_len(16'(SETTLE));
        stop_mode_i = 1;
        step(1);
        chk("reg stop open", 16'h0000, {15'h0000, regulator_stop_o});
        stop_mode_i = 0;
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    initial begin
        #200000;
        n_fail++;
        give_verdict();
    end

    initial begin
        step(12);
        rst_b_i = 1;
        settle_len(16'(SETTLE));
        t_pin();
        t_wd1();
        t_wd2();
        t_wd1();
        t_freeze();
        t_order();
        t_por();
        give_verdict();
    end
endmodule
